// File: design/slt_lvl_det.sv
`timescale 1ns/10ps
`default_nettype none
module slt_lvl_det (
	// Clock and reset
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	// Detector link
	slt_det_if.det     det_io
);

	typedef struct packed {
		logic armed;
		logic trig;
		logic beyond;
	} slt_det_state_t;

	slt_det_state_t                s_q;
	slt_det_state_t                s_d;
	logic signed [slt_pkg::VW-1:0] lvl;
	logic signed [slt_pkg::VW-1:0] arm_lvl;
	logic                          past_lvl;
	logic                          arm_ok;

	// ----------------------------------------
	// Crossing and arming
	// ----------------------------------------
	always_comb begin
		lvl      = slt_pkg::VW'(det_io.level);
		arm_lvl  = det_io.dir_neg ? lvl + $signed({2'h0, det_io.hyst})
		                          : lvl - $signed({2'h0, det_io.hyst});
		past_lvl = det_io.dir_neg ? (det_io.value < lvl) : (det_io.value > lvl);
		arm_ok   = det_io.dir_neg ? (det_io.value > arm_lvl) : (det_io.value < arm_lvl);
		s_d      = s_q;
		s_d.trig = 1'b0;
		if (det_io.clr) begin
			s_d.armed  = 1'b0;
			s_d.beyond = 1'b0;
		end else if (det_io.valid) begin
			s_d.beyond = past_lvl;
			if (s_q.armed && past_lvl) begin
				s_d.trig  = 1'b1;
				s_d.armed = 1'b0;
			end else if (arm_ok) begin
				s_d.armed = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign det_io.trig   = s_q.trig;
	assign det_io.beyond = s_q.beyond;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_ONE_PULSE: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		s_q.trig |=> !s_q.trig)
		else $error("Trigger pulse longer than one cycle");

	AST_STRICT: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(s_q.trig) |-> $past(det_io.valid && s_q.armed && past_lvl && !det_io.clr))
		else $error("Trigger without strict crossing of an armed detector");

	AST_CLR: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		det_io.clr |=> (!s_q.armed && !s_q.trig))
		else $error("Recording start did not clear detector");

	AST_REARM: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(s_q.armed) |-> $past(det_io.valid && arm_ok))
		else $error("Detector armed inside hysteresis band");

endmodule : slt_lvl_det
`default_nettype wire

// File: design/slt_top.sv
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Delay register lets detector follow slope
// - Compare result against level, larger or smaller
// - Trigger only on crossing in direction
// - Rearm only after leaving hysteresis band
// - Equal sample never triggers
// - Trigger on first sample past level
// - Already beyond at start gives no trigger
// - Two detectors: primary and secondary
// - Basic mode uses primary detector only
// - Dual mode triggers leaving either level
// - Secondary direction opposite to primary
// - Inverted directions trigger on range entry
// - One hysteresis value for both detectors
// - Qualifier modes drive qualifier, not trigger
// - Channel triggers ORed, merged with external
// - Unarmed enabled qualifier blocks recorder trigger
// - Common input edge, per card enable
// - Common output polarity, per card enable
// - Single alarm active while beyond level
// - Dual alarm active while beyond either
// - Channel alarms ORed onto one output
// - Disabled detector gives no trigger
module slt_top (
	// Clock and reset
	input  wire logic                               sys_clk_in,
	input  wire logic                               rstn_in,
	// Register port
	input  wire logic [7:0]                         reg_addr_in,
	input  wire logic [31:0]                        reg_wdata_in,
	input  wire logic                               reg_wr_in,
	input  wire logic                               reg_rd_in,
	output logic      [31:0]                        reg_rdata_out,
	// Sample stream
	input  wire logic [slt_pkg::NCH*slt_pkg::SW-1:0] smp_data_in,
	input  wire logic                               smp_valid_in,
	input  wire logic                               rec_start_in,
	// Pins
	input  wire logic                               ext_trig_in,
	input  wire logic                               alarm_chain_in,
	output logic                                    rec_trig_out,
	output logic                                    ext_trig_out,
	output logic                                    alarm_out
);

	localparam int NCH = slt_pkg::NCH;
	localparam int SW  = slt_pkg::SW;
	localparam int DLY = slt_pkg::DLY;

	typedef struct packed {
		logic [3:0]                           glb;
		logic [NCH-1:0][7:0]                  cfg;
		logic [NCH-1:0][SW-1:0]               lvlp;
		logic [NCH-1:0][SW-1:0]               lvls;
		logic [NCH-1:0][SW-1:0]               hyst;
		logic [NCH-1:0]                       seen;
		logic [2:0]                           ext_s;
		logic                                 ext_st;
		logic [2:0]                           alm_s;
		logic                                 alm_st;
		logic [NCH-1:0][DLY-1:0][SW-1:0]      dly;
		logic                                 rec_trig;
		logic                                 ext_out;
		logic                                 alarm;
		logic [31:0]                          rdata;
	} slt_top_state_t;

	slt_top_state_t s_q;
	slt_top_state_t s_d;
	logic [1:0]     rst_sync_q;
	logic           rst_n;
	logic [NCH-1:0] ctrig;
	logic [NCH-1:0] q_en;
	logic [NCH-1:0] q_arm;
	logic [NCH-1:0] c_alarm;
	logic           block;
	logic           ext_edge;
	logic [7:0]     rel;
	logic [1:0]     chi;
	logic           in_ch;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// ----------------------------------------
	// Channel detectors
	// ----------------------------------------
	for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
		slt_det_if                     pif ();
		slt_det_if                     sif ();
		logic [SW-1:0]                 cur;
		logic [SW-1:0]                 old;
		logic [1:0]                    dsel;
		logic [2:0]                    tm;
		logic [1:0]                    am;
		logic signed [slt_pkg::VW-1:0] val;

		assign cur  = smp_data_in[ch*SW +: SW];
		assign dsel = s_q.cfg[ch][slt_pkg::CFG_DLY_LSB +: 2];
		assign tm   = s_q.cfg[ch][slt_pkg::CFG_TM_LSB +: 3];
		assign am   = s_q.cfg[ch][slt_pkg::CFG_AM_LSB +: 2];
		assign old  = s_q.dly[ch][dsel - 2'h1];
		// Difference against an older sample gives slope
		assign val  = (dsel == 2'h0) ? slt_pkg::VW'($signed(cur))
		            : slt_pkg::VW'($signed(cur)) - slt_pkg::VW'($signed(old));

		assign pif.valid   = smp_valid_in;
		assign pif.clr     = rec_start_in;
		assign pif.value   = val;
		assign pif.level   = s_q.lvlp[ch];
		assign pif.hyst    = s_q.hyst[ch];
		assign pif.dir_neg = s_q.cfg[ch][slt_pkg::CFG_DIR_BIT];
		assign sif.valid   = smp_valid_in;
		assign sif.clr     = rec_start_in;
		assign sif.value   = val;
		assign sif.level   = s_q.lvls[ch];
		assign sif.hyst    = s_q.hyst[ch];
		assign sif.dir_neg = ~s_q.cfg[ch][slt_pkg::CFG_DIR_BIT];

		slt_lvl_det u_prim (
			.clk_in   (sys_clk_in),
			.rst_n_in (rst_n),
			.det_io   (pif.det)
		);

		slt_lvl_det u_sec (
			.clk_in   (sys_clk_in),
			.rst_n_in (rst_n),
			.det_io   (sif.det)
		);

		assign ctrig[ch] = ((tm == slt_pkg::TM_BASIC) & pif.trig)
		                 | ((tm == slt_pkg::TM_DUAL) & (pif.trig | sif.trig));
		assign q_en[ch]  = (tm == slt_pkg::TM_QBASIC) | (tm == slt_pkg::TM_QDUAL);
		assign q_arm[ch] = pif.beyond | ((tm == slt_pkg::TM_QDUAL) & sif.beyond);
		assign c_alarm[ch] = ((am == slt_pkg::AM_SINGLE) & pif.beyond)
		                   | ((am == slt_pkg::AM_DUAL) & (pif.beyond | sif.beyond));

		AST_OFF: assert property (
			@(posedge sys_clk_in) disable iff (!rst_n)
			(tm == slt_pkg::TM_OFF) |-> !ctrig[ch])
			else $error("Disabled channel produced a trigger");
	end

	// ----------------------------------------
	// Combine and registers
	// ----------------------------------------
	assign block = |(q_en & ~q_arm);
	assign rel   = reg_addr_in - slt_pkg::ADDR_CH_BASE;
	assign chi   = rel[5:4];
	assign in_ch = (reg_addr_in >= slt_pkg::ADDR_CH_BASE) && (rel[7:4] < 4'(NCH));

	always_comb begin
		s_d       = s_q;
		s_d.rdata = 32'h0;

		// Pin inputs: change counts once stages two and three agree
		s_d.ext_s = {s_q.ext_s[1:0], ext_trig_in};
		s_d.alm_s = {s_q.alm_s[1:0], alarm_chain_in};
		if (s_q.ext_s[1] == s_q.ext_s[2]) begin
			s_d.ext_st = s_q.ext_s[2];
		end
		if (s_q.alm_s[1] == s_q.alm_s[2]) begin
			s_d.alm_st = s_q.alm_s[2];
		end
		ext_edge = (s_d.ext_st != s_q.ext_st)
		         && (s_d.ext_st != s_q.glb[slt_pkg::GLB_EXT_FALL]);

		if (smp_valid_in) begin
			for (int c = 0; c < NCH; c++) begin
				s_d.dly[c] = {s_q.dly[c][DLY-2:0], smp_data_in[c*SW +: SW]};
			end
		end

		s_d.rec_trig = ((|ctrig) | (s_q.glb[slt_pkg::GLB_EXT_EN] & ext_edge)) & ~block;
		s_d.ext_out  = (s_q.glb[slt_pkg::GLB_OUT_EN] & s_q.rec_trig)
		             ^ s_q.glb[slt_pkg::GLB_OUT_LOW];
		s_d.alarm    = (|c_alarm) | s_q.alm_st;

		if (reg_wr_in) begin
			if (reg_addr_in == slt_pkg::ADDR_GLOBAL) begin
				s_d.glb = reg_wdata_in[3:0];
			end else if (reg_addr_in == slt_pkg::ADDR_STATUS) begin
				s_d.seen = s_q.seen & ~reg_wdata_in[slt_pkg::ST_SEEN_LSB +: NCH];
			end else if (in_ch) begin
				case (rel[3:0])
					slt_pkg::OFS_CFG: begin
						s_d.cfg[chi] = reg_wdata_in[7:0];
					end
					slt_pkg::OFS_LVLP: begin
						s_d.lvlp[chi] = reg_wdata_in[SW-1:0];
					end
					slt_pkg::OFS_LVLS: begin
						s_d.lvls[chi] = reg_wdata_in[SW-1:0];
					end
					slt_pkg::OFS_HYST: begin
						s_d.hyst[chi] = reg_wdata_in[SW-1:0];
					end
					default: begin
					end
				endcase
			end
		end
		// New triggers win over a clear in the same cycle
		s_d.seen = s_d.seen | ctrig;

		if (reg_rd_in) begin
			if (reg_addr_in == slt_pkg::ADDR_GLOBAL) begin
				s_d.rdata = {28'h0, s_q.glb};
			end else if (reg_addr_in == slt_pkg::ADDR_STATUS) begin
				s_d.rdata[slt_pkg::ST_SEEN_LSB +: NCH] = s_q.seen;
				s_d.rdata[slt_pkg::ST_QARM_LSB +: NCH] = q_arm;
				s_d.rdata[slt_pkg::ST_ALM_LSB +: NCH]  = c_alarm;
			end else if (in_ch) begin
				case (rel[3:0])
					slt_pkg::OFS_CFG: begin
						s_d.rdata = {24'h0, s_q.cfg[chi]};
					end
					slt_pkg::OFS_LVLP: begin
						s_d.rdata = {16'h0, s_q.lvlp[chi]};
					end
					slt_pkg::OFS_LVLS: begin
						s_d.rdata = {16'h0, s_q.lvls[chi]};
					end
					slt_pkg::OFS_HYST: begin
						s_d.rdata = {16'h0, s_q.hyst[chi]};
					end
					default: begin
						s_d.rdata = 32'h0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_q      <= '0;
			s_q.glb  <= slt_pkg::RST_GLB;
			s_q.cfg  <= {NCH{slt_pkg::RST_CFG}};
			s_q.lvlp <= {NCH{slt_pkg::RST_LVL}};
			s_q.lvls <= {NCH{slt_pkg::RST_LVL}};
			s_q.hyst <= {NCH{slt_pkg::RST_HYST}};
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_out = s_q.rdata;
	assign rec_trig_out  = s_q.rec_trig;
	assign ext_trig_out  = s_q.ext_out;
	assign alarm_out     = s_q.alarm;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_QUAL_BLOCK: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		block |=> !rec_trig_out)
		else $error("Recorder trigger passed an unarmed qualifier");

	AST_CHAN_OR: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		((|ctrig) && !block) |=> rec_trig_out)
		else $error("Channel trigger did not reach recorder trigger");

	AST_EXT_IN: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		(ext_edge && s_q.glb[slt_pkg::GLB_EXT_EN] && !block) |=> rec_trig_out)
		else $error("External edge did not trigger recorder");

	AST_EXT_OUT: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		(rec_trig_out && s_q.glb[slt_pkg::GLB_OUT_EN])
		|=> (ext_trig_out != $past(s_q.glb[slt_pkg::GLB_OUT_LOW])))
		else $error("External output not active after recorder trigger");

	AST_ALARM: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		(|c_alarm) |=> alarm_out)
		else $error("Channel alarm missing on alarm output");

	AST_RD_ONCE: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n)
		!reg_rd_in |=> (reg_rdata_out == 32'h0))
		else $error("Read data outside its cycle");

endmodule : slt_top
`default_nettype wire

// File: inc/slt_det_if.sv
`timescale 1ns/10ps
`default_nettype none
interface slt_det_if;
	logic                          valid;
	logic                          clr;
	logic signed [slt_pkg::VW-1:0] value;
	logic signed [slt_pkg::SW-1:0] level;
	logic        [slt_pkg::SW-1:0] hyst;
	logic                          dir_neg;
	logic                          trig;
	logic                          beyond;

	modport ctl (output valid, clr, value, level, hyst, dir_neg, input trig, beyond);
	modport det (input valid, clr, value, level, hyst, dir_neg, output trig, beyond);
endinterface : slt_det_if
`default_nettype wire

// File: inc/slt_pkg.sv
package slt_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NCH = 4;
	localparam int SW  = 16;
	localparam int VW  = 18;
	localparam int DLY = 3;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_GLOBAL  = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_CH_BASE = 8'h10;
	localparam logic [3:0] OFS_CFG      = 4'h0;
	localparam logic [3:0] OFS_LVLP     = 4'h4;
	localparam logic [3:0] OFS_LVLS     = 4'h8;
	localparam logic [3:0] OFS_HYST     = 4'hc;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int GLB_EXT_FALL = 0;
	localparam int GLB_OUT_LOW  = 1;
	localparam int GLB_EXT_EN   = 2;
	localparam int GLB_OUT_EN   = 3;
	localparam int CFG_TM_LSB   = 0;
	localparam int CFG_AM_LSB   = 3;
	localparam int CFG_DIR_BIT  = 5;
	localparam int CFG_DLY_LSB  = 6;
	localparam int ST_SEEN_LSB  = 0;
	localparam int ST_QARM_LSB  = 4;
	localparam int ST_ALM_LSB   = 8;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [3:0]    RST_GLB  = 4'h0;
	localparam logic [7:0]    RST_CFG  = 8'h00;
	localparam logic [SW-1:0] RST_LVL  = 16'h0000;
	localparam logic [SW-1:0] RST_HYST = 16'h0000;

	// ----------------------------------------
	// Modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		TM_OFF    = 3'h0,
		TM_BASIC  = 3'h1,
		TM_DUAL   = 3'h2,
		TM_QBASIC = 3'h3,
		TM_QDUAL  = 3'h4
	} slt_tmode_t;

	typedef enum logic [1:0] {
		AM_OFF    = 2'h0,
		AM_SINGLE = 2'h1,
		AM_DUAL   = 2'h2
	} slt_amode_t;

endpackage : slt_pkg

// File: tb/slt_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
module slt_adc_model (
	// Clock
	input  wire logic        clk_in,
	// Bench request
	input  wire logic        req_in,
	input  wire logic [63:0] val_in,
	// Sample stream
	output logic      [63:0] data_out,
	output logic             valid_out
);
	initial begin
		data_out  = 64'h0;
		valid_out = 1'b0;
	end
	// Idle cycles carry inverted data so a stale word never looks valid
	always @(posedge clk_in) begin
		valid_out <= req_in;
		data_out  <= req_in ? val_in : ~data_out;
	end
endmodule : slt_adc_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic        wen = 1'b0;
	logic        ren = 1'b0;
	logic        req = 1'b0;
	logic        start = 1'b0;
	logic        exin = 1'b0;
	logic        chain = 1'b0;
	logic [63:0] val = 64'h0;
	logic [63:0] sdat;
	logic [47:0] oth = 48'h0;
	logic [31:0] rdat, rv;
	logic [15:0] lf = 16'h0016;
	logic [3:0]  tp, ep, ap;
	logic        sval, rtrig, etrig, alarm, armed, e;
	int          error_cnt = 0;
	int          num_checks = 0;
	int          n;

	always #50 clk = ~clk;

	slt_top u_slt_top (.sys_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr),
		.reg_wdata_in(wdat), .reg_wr_in(wen), .reg_rd_in(ren), .reg_rdata_out(rdat),
		.smp_data_in(sdat), .smp_valid_in(sval), .rec_start_in(start),
		.ext_trig_in(exin), .alarm_chain_in(chain), .rec_trig_out(rtrig),
		.ext_trig_out(etrig), .alarm_out(alarm));
	slt_adc_model u_slt_adc_model (.clk_in(clk), .req_in(req), .val_in(val),
		.data_out(sdat), .valid_out(sval));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task stop_test;
		if (error_cnt == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	function logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : nx

	function logic [7:0] mk(input logic [2:0] tm, input logic [1:0] am, input logic ng,
		input logic [1:0] dl);
		return {dl, ng, am, tm};
	endfunction : mk

	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wen  <= 1'b1;
		@(posedge clk);
		wen <= 1'b0;
	endtask : wreg

	task rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		ren  <= 1'b1;
		@(posedge clk);
		ren <= 1'b0;
		#1;
		d = rdat;
	endtask : rreg

	task cfg(input logic [7:0] b, input logic [7:0] m, input logic [15:0] p, s, h);
		wreg(b, {24'h0, m});
		wreg(b + 8'h04, {16'h0, p});
		wreg(b + 8'h08, {16'h0, s});
		wreg(b + 8'h0c, {16'h0, h});
	endtask : cfg

	// Sample on channel 0, others from oth; records outputs after the sample edge
	task t(input logic [15:0] v, input logic [3:0] ex);
		@(posedge clk);
		val <= {oth, v};
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			#1;
			tp[i] = rtrig;
			ep[i] = etrig;
			ap[i] = alarm;
		end
		check({28'h0, tp}, {28'h0, ex});
	endtask : t

	task pulse_start;
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
	endtask : pulse_start

	task ext(input logic lv);
		@(posedge clk);
		exin <= lv;
		n = 0;
		repeat (10) begin
			@(posedge clk);
			#1;
			n += (rtrig === 1'b1);
		end
	endtask : ext

	initial begin
		#2000000;
		error_cnt++;
		stop_test;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		for (int a = 0; a < 24; a++) begin
			rreg(8'(a * 4), rv);
			check(rv, 32'h0);
		end
		wreg(8'h10, 32'hffffffff);
		rreg(8'h10, rv);
		check(rv, 32'h000000ff);
		cfg(8'h10, mk(slt_pkg::TM_BASIC, 0, 0, 0), 100, 0, 0);
		t(50, 0);
		t(100, 0);
		t(101, 1);
		t(150, 0);
		t(50, 0);
		pulse_start;
		t(200, 0);
		t(50, 0);
		t(101, 1);
		cfg(8'h10, mk(slt_pkg::TM_BASIC, 0, 1, 0), 100, 0, 0);
		t(150, 0);
		t(100, 0);
		t(99, 1);
		cfg(8'h10, mk(slt_pkg::TM_BASIC, 0, 0, 0), 100, 0, 20);
		t(50, 0);
		t(150, 1);
		t(90, 0);
		t(150, 0);
		t(70, 0);
		t(150, 1);
		cfg(8'h10, mk(slt_pkg::TM_BASIC, 0, 0, 1), 10, 0, 0);
		t(0, 0);
		t(100, 1);
		t(200, 0);
		t(200, 0);
		t(300, 1);
		cfg(8'h10, mk(slt_pkg::TM_DUAL, 0, 0, 0), 100, -16'sd100, 20);
		t(0, 0);
		t(-16'sd150, 1);
		t(-16'sd90, 0);
		t(-16'sd150, 0);
		t(0, 0);
		t(150, 1);
		cfg(8'h10, mk(slt_pkg::TM_DUAL, 0, 1, 0), 100, -16'sd100, 0);
		// Secondary is still armed from the last mode; start clears it
		pulse_start;
		t(200, 0);
		t(0, 1);
		t(-16'sd200, 0);
		t(0, 1);
		wreg(8'h10, {24'h0, mk(slt_pkg::TM_OFF, 0, 0, 0)});
		t(50, 0);
		t(150, 0);
		// Qualifier gating
		cfg(8'h10, mk(slt_pkg::TM_BASIC, 0, 0, 0), 100, 0, 0);
		cfg(8'h20, mk(slt_pkg::TM_QBASIC, 0, 0, 0), 1000, 0, 0);
		t(50, 0);
		t(150, 0);
		oth[15:0] = 16'd2000;
		t(50, 0);
		rreg(8'h04, rv);
		check(rv & 32'hf0, 32'h20);
		t(150, 1);
		cfg(8'h20, mk(slt_pkg::TM_QDUAL, 0, 0, 0), 1000, -16'sd1000, 0);
		oth[15:0] = 16'h0;
		t(50, 0);
		t(150, 0);
		oth[15:0] = -16'sd2000;
		t(50, 0);
		t(150, 1);
		wreg(8'h20, 32'h0);
		// External trigger out and in
		wreg(8'h00, 32'ha);
		t(50, 0);
		t(150, 1);
		check({28'h0, ep}, 32'hd);
		wreg(8'h00, 32'h8);
		t(50, 0);
		t(150, 1);
		check({28'h0, ep}, 32'h2);
		wreg(8'h00, 32'h2);
		t(50, 0);
		t(150, 1);
		check({28'h0, ep}, 32'hf);
		wreg(8'h00, 32'h4);
		ext(1);
		check(32'(n), 1);
		ext(0);
		check(32'(n), 0);
		wreg(8'h00, 32'h5);
		ext(1);
		check(32'(n), 0);
		ext(0);
		check(32'(n), 1);
		wreg(8'h00, 32'h1);
		ext(1);
		ext(0);
		check(32'(n), 0);
		wreg(8'h00, 32'h0);
		// Alarms
		wreg(8'h30, {24'h0, mk(0, slt_pkg::AM_SINGLE, 0, 0)});
		cfg(8'h40, mk(0, slt_pkg::AM_DUAL, 0, 0), 100, -16'sd100, 0);
		oth = {16'h0, 16'd10, 16'h0};
		t(50, 0);
		check({28'h0, ap}, 32'hf);
		oth = {16'h0, -16'sd10, 16'h0};
		t(50, 0);
		check({28'h0, ap}, 32'h0);
		oth = {-16'sd150, -16'sd10, 16'h0};
		t(50, 0);
		check({28'h0, ap}, 32'hf);
		oth = {16'd150, -16'sd10, 16'h0};
		t(50, 0);
		check({28'h0, ap}, 32'hf);
		oth = 48'h0;
		t(50, 0);
		check({28'h0, ap}, 32'h0);
		@(posedge clk);
		chain <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		check({31'h0, alarm}, 1);
		@(posedge clk);
		chain <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		check({31'h0, alarm}, 0);
		// Random samples against a reference crossing detector
		cfg(8'h10, mk(slt_pkg::TM_BASIC, 0, 0, 0), 100, 0, 16);
		pulse_start;
		armed = 1'b0;
		for (int i = 0; i < 40; i++) begin
			lf = nx(lf);
			oth = {3{lf}};
			e = armed && (lf[7:0] > 8'd100);
			if (e)
				armed = 1'b0;
			else if (lf[7:0] < 8'd84)
				armed = 1'b1;
			t({8'h0, lf[7:0]}, {3'h0, e});
		end
		stop_test;
	end
endmodule : tb_top
`default_nettype wire
